// ==== ttc_timer_two.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ttc_defines.svh"
// Timer two: 16-bit or split 8-bit auto-reload counter with capture mode.
module ttc_timer_two
  import ttc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_rd,
  input wire logic bit_wr,
  input wire logic [7:0] bit_addr,
  input wire logic bit_val,
  input wire logic high_byte_clock_sel,
  input wire logic low_byte_clock_sel,
  input wire logic timer_irq_enable,
  input wire logic comparator0_in,
  input wire logic rtc_osc_in,
  output logic [7:0] sfr_rdata_r,
  output logic irq_req_r
);

  logic [7:0] ctrl_r;
  logic [7:0] ctrl_nxt;
  logic [7:0] count_lo_r;
  logic [7:0] count_lo_nxt;
  logic [7:0] count_hi_r;
  logic [7:0] count_hi_nxt;
  logic [7:0] reload_lo_r;
  logic [7:0] reload_lo_nxt;
  logic [7:0] reload_hi_r;
  logic [7:0] reload_hi_nxt;
  logic [3:0] div12_r;
  logic [2:0] div8_r;
  logic cmp_rise;
  logic osc_rise;

  // True when a byte stands at its top value, so that its next step wraps.
  function automatic logic ttc_at_max(input logic [7:0] value);
    ttc_at_max = (value == `TTC_BYTE_MAX);
  endfunction : ttc_at_max

  // True when the register port address matches one register.
  function automatic logic ttc_hit(input logic [7:0] addr, input logic [7:0] target);
    ttc_hit = (addr == target);
  endfunction : ttc_hit

  // One step of a counter byte; a wrap loads zero or the reload byte.
  function automatic logic [7:0] ttc_step(input logic [7:0] value, input logic [7:0] reload,
                                           input logic use_reload);
    if (ttc_at_max(value)) begin
      ttc_step = use_reload ? reload : `TTC_BYTE_RESET;
    end else begin
      ttc_step = value + 8'h01;
    end
  endfunction : ttc_step

  // Both outside sources are synchronized and edge detected before any use.
  ttc_edge_sync u_cmp_sync (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .async_in(comparator0_in),
    .rise_r(cmp_rise)
  );
  ttc_edge_sync u_osc_sync (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .async_in(rtc_osc_in),
    .rise_r(osc_rise)
  );

  // Control field decode.
  wire ttc_alt_sel_t alt_sel = ttc_alt_sel_t'(ctrl_r[1:0]);
  wire split = ctrl_r[`TTC_BIT_SPLIT];
  wire run = ctrl_r[`TTC_BIT_RUN];
  wire capture_en = ctrl_r[`TTC_BIT_CAPTURE_EN];
  wire low_irq_en = ctrl_r[`TTC_BIT_LOW_IRQ_EN];

  // Prescaled ticks of one system clock each.
  wire div12_tick = (div12_r == `TTC_DIV12_LAST);
  wire osc8_tick = osc_rise & (div8_r == `TTC_DIV8_LAST);

  // Alternate clock and capture trigger chosen by the selector.
  wire alt_tick = (alt_sel == TTC_ALT_CMP_CAP_OSC) ? cmp_rise :
                  (alt_sel == TTC_ALT_OSC_CAP_CMP) ? osc8_tick : div12_tick;
  wire cap_trig = ctrl_r[1] ? cmp_rise : osc8_tick;
  wire capture_evt = capture_en & cap_trig;

  // Per-byte clock choice; the alternate clock serves both bytes in split mode.
  wire lo_clk_tick = low_byte_clock_sel | alt_tick;
  wire hi_clk_tick = high_byte_clock_sel | alt_tick;

  // Top-value detection of both count bytes.
  wire lo_at_max = ttc_at_max(count_lo_r);
  wire hi_at_max = ttc_at_max(count_hi_r);

  // Count enables: 16-bit mode runs on the low selector, split low byte always runs.
  wire tick16 = ~split & run & lo_clk_tick;
  wire tick_lo = split ? lo_clk_tick : tick16;
  wire tick_hi = split ? (run & hi_clk_tick) : (tick16 & lo_at_max);
  wire lo_ovf = tick_lo & lo_at_max;
  wire hi_ovf = tick_hi & hi_at_max;
  wire full_wrap = ~split & hi_ovf;
  wire reload_lo_use = split | (full_wrap & ~capture_en);
  wire reload_hi_use = split | ~capture_en;
  wire set_high = hi_ovf | capture_evt;
  wire set_low = lo_ovf;

  // Address hits of the byte-wide register port, shared by writes and reads.
  wire hit_ctrl = ttc_hit(sfr_addr, `TTC_ADDR_CTRL);
  wire hit_rl_lo = ttc_hit(sfr_addr, `TTC_ADDR_RELOAD_LO);
  wire hit_rl_hi = ttc_hit(sfr_addr, `TTC_ADDR_RELOAD_HI);
  wire hit_cnt_lo = ttc_hit(sfr_addr, `TTC_ADDR_COUNT_LO);
  wire hit_cnt_hi = ttc_hit(sfr_addr, `TTC_ADDR_COUNT_HI);

  // Software writes, byte-wide or by bit address.
  wire ctrl_byte_wr = sfr_wr & hit_ctrl;
  wire ctrl_bit_wr = bit_wr & (bit_addr[7:3] == `TTC_BITADDR_BASE);
  wire wr_rl_lo = sfr_wr & hit_rl_lo;
  wire wr_rl_hi = sfr_wr & hit_rl_hi;
  wire wr_cnt_lo = sfr_wr & hit_cnt_lo;
  wire wr_cnt_hi = sfr_wr & hit_cnt_hi;

  // Control next value: write first, then hardware sets override the flags.
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (ctrl_byte_wr) begin
      ctrl_nxt = sfr_wdata;
    end else if (ctrl_bit_wr) begin
      ctrl_nxt[bit_addr[2:0]] = bit_val;
    end
    ctrl_nxt[`TTC_BIT_HIGH_FLAG] = ctrl_nxt[`TTC_BIT_HIGH_FLAG] | set_high;
    ctrl_nxt[`TTC_BIT_LOW_FLAG] = ctrl_nxt[`TTC_BIT_LOW_FLAG] | set_low;
  end

  // Counter next values; a software write to a count byte wins over counting.
  always_comb begin
    count_lo_nxt = count_lo_r;
    count_hi_nxt = count_hi_r;
    if (wr_cnt_lo) begin
      count_lo_nxt = sfr_wdata;
    end else if (tick_lo) begin
      count_lo_nxt = ttc_step(count_lo_r, reload_lo_r, reload_lo_use);
    end
    if (wr_cnt_hi) begin
      count_hi_nxt = sfr_wdata;
    end else if (tick_hi) begin
      count_hi_nxt = ttc_step(count_hi_r, reload_hi_r, reload_hi_use);
    end
  end

  // Reload next values; a capture takes the running count over software.
  always_comb begin
    reload_lo_nxt = wr_rl_lo ? sfr_wdata : reload_lo_r;
    reload_hi_nxt = wr_rl_hi ? sfr_wdata : reload_hi_r;
    if (capture_evt) begin
      reload_lo_nxt = count_lo_r;
      reload_hi_nxt = count_hi_r;
    end
  end

  // Read data decode; unmapped addresses read zero.
  wire [7:0] rd_mux = hit_ctrl ? ctrl_r :
                      hit_rl_lo ? reload_lo_r :
                      hit_rl_hi ? reload_hi_r :
                      hit_cnt_lo ? count_lo_r :
                      hit_cnt_hi ? count_hi_r : 8'h00;

  // Interrupt request level from the flags and enables.
  wire hi_req = ctrl_r[`TTC_BIT_HIGH_FLAG];
  wire lo_req = low_irq_en & ctrl_r[`TTC_BIT_LOW_FLAG];
  wire irq_nxt = timer_irq_enable & (hi_req | lo_req);

  // Timer registers.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= `TTC_CTRL_RESET;
      count_lo_r <= `TTC_BYTE_RESET;
      count_hi_r <= `TTC_BYTE_RESET;
      reload_lo_r <= `TTC_BYTE_RESET;
      reload_hi_r <= `TTC_BYTE_RESET;
    end else if (ce) begin
      ctrl_r <= ctrl_nxt;
      count_lo_r <= count_lo_nxt;
      count_hi_r <= count_hi_nxt;
      reload_lo_r <= reload_lo_nxt;
      reload_hi_r <= reload_hi_nxt;
    end
  end

  // Prescalers: system clock by twelve and oscillator edges by eight.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div12_r <= 4'h0;
      div8_r <= 3'h0;
    end else if (ce) begin
      div12_r <= div12_tick ? 4'h0 : div12_r + 4'h1;
      if (osc_rise) begin
        div8_r <= div8_r + 3'h1;
      end
    end
  end

  // Registered outputs.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sfr_rdata_r <= 8'h00;
      irq_req_r <= 1'b0;
    end else if (ce) begin
      if (sfr_rd) begin
        sfr_rdata_r <= rd_mux;
      end
      irq_req_r <= irq_nxt;
    end
  end

endmodule : ttc_timer_two
`default_nettype wire

// ==== ttc_defines.svh ====
`ifndef TTC_DEFINES_SVH
`define TTC_DEFINES_SVH

`define TTC_ADDR_CTRL 8'hC8
`define TTC_ADDR_RELOAD_LO 8'hCA
`define TTC_ADDR_RELOAD_HI 8'hCB
`define TTC_ADDR_COUNT_LO 8'hCC
`define TTC_ADDR_COUNT_HI 8'hCD
`define TTC_BITADDR_BASE 5'h19
`define TTC_CTRL_RESET 8'h00
`define TTC_BYTE_RESET 8'h00
`define TTC_BIT_HIGH_FLAG 7
`define TTC_BIT_LOW_FLAG 6
`define TTC_BIT_LOW_IRQ_EN 5
`define TTC_BIT_CAPTURE_EN 4
`define TTC_BIT_SPLIT 3
`define TTC_BIT_RUN 2
`define TTC_DIV12_LAST 4'hB
`define TTC_DIV8_LAST 3'h7
`define TTC_BYTE_MAX 8'hFF

`endif

// ==== ttc_pkg.sv ====
package ttc_pkg;

  // Codes of the two-bit alternate clock and capture trigger selector.
  typedef enum logic [1:0] {
    TTC_ALT_DIV12_CAP_OSC = 2'h0,
    TTC_ALT_CMP_CAP_OSC = 2'h1,
    TTC_ALT_DIV12_CAP_CMP = 2'h2,
    TTC_ALT_OSC_CAP_CMP = 2'h3
  } ttc_alt_sel_t;

endpackage : ttc_pkg

// ==== ttc_edge_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
// Two-stage synchronizer followed by a rising-edge detector.
module ttc_edge_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic async_in,
  output logic rise_r
);

  logic meta_r;
  logic sync_r;
  logic prev_r;

  // The first stage is read only by the second; the edge is taken past it.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
      rise_r <= 1'b0;
    end else if (ce) begin
      meta_r <= async_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
      rise_r <= sync_r & ~prev_r;
    end
  end

endmodule : ttc_edge_sync
`default_nettype wire

// ==== ttc_timer_two_props.sv ====
`timescale 1ns/1ps
`default_nettype none
// Watches the register port and the request output of timer two.
module ttc_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_rd,
  input wire logic bit_wr,
  input wire logic [7:0] bit_addr,
  input wire logic bit_val,
  input wire logic timer_irq_enable,
  input wire logic [7:0] sfr_rdata_r,
  input wire logic irq_req_r
);
  // Decodes of accesses; a byte write to control wins over a bit write.
  wire logic bw = ce && sfr_wr && sfr_addr == 8'hC8;
  wire logic cw = bw || (ce && bit_wr && bit_addr[7:3] == 5'h19);
  wire logic rc = ce && sfr_rd && sfr_addr == 8'hC8;
  wire logic um = !(sfr_addr inside {8'hC8, 8'hCA, 8'hCB, 8'hCC, 8'hCD});
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  a_flag_sticky: assert property (irq_req_r && timer_irq_enable && !$past(cw) |=> irq_req_r)
    else $error("request dropped without a clear");
  a_irq_gate: assert property (ce && !timer_irq_enable |=> !irq_req_r)
    else $error("request while disabled");
  a_irq_cause: assert property ($rose(irq_req_r) |-> $past(timer_irq_enable))
    else $error("request rose while disabled");
  a_rdata_hold: assert property (!(ce && sfr_rd) |=> $stable(sfr_rdata_r))
    else $error("read data moved without a read");
  a_unmap_zero: assert property (ce && sfr_rd && um |=> sfr_rdata_r == 8'h00)
    else $error("unmapped read not zero");
  a_ce_freeze: assert property (!ce |=> $stable(irq_req_r) && $stable(sfr_rdata_r))
    else $error("outputs moved with enable low");
  a_ctrl_back: assert property (bw ##1 rc |=> sfr_rdata_r[5:0] == $past(sfr_wdata[5:0], 2))
    else $error("control byte readback wrong");
  a_bit_back: assert property (cw && !bw && bit_addr[2:0] < 3'h6 ##1 rc
    |=> sfr_rdata_r[$past(bit_addr[2:0], 2)] == $past(bit_val, 2)) else $error("bit write readback wrong");
endmodule : ttc_chk
bind ttc_timer_two ttc_chk ttc_chk_i (.clk, .rst_n, .ce, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rd,
  .bit_wr, .bit_addr, .bit_val, .timer_irq_enable, .sfr_rdata_r, .irq_req_r);
`default_nettype wire

// ==== test_ttc_timer_two.sv ====
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench for timer two.
module test_ttc_timer_two;
  logic clk = 0, rst_n = 0, ce = 1, sfr_wr = 0, sfr_rd = 0, bit_wr = 0, bit_val = 0;
  logic high_byte_clock_sel = 0, low_byte_clock_sel = 0, timer_irq_enable = 1;
  logic comparator0_in = 0, rtc_osc_in = 0, irq_req_r;
  logic [7:0] sfr_addr = 0, sfr_wdata = 0, bit_addr = 0, sfr_rdata_r, seed = 8'h56, d;
  int num_errors = 0, n_checks = 0, cyc = 0, b;
  always #25 clk = ~clk;
  ttc_timer_two ttc_timer_two_i (.clk, .rst_n, .ce, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rd, .bit_wr,
    .bit_addr, .bit_val, .high_byte_clock_sel, .low_byte_clock_sel, .timer_irq_enable, .comparator0_in,
    .rtc_osc_in, .sfr_rdata_r, .irq_req_r);
  // Cuts a hang short well beyond the expected run length.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      num_errors++;
      final_report();
    end
  end
  // Xorshift step; a nonzero state never reaches zero.
  function automatic logic [7:0] xs(input logic [7:0] s);
    logic [7:0] x;
    x = s ^ (s << 3);
    x = x ^ (x >> 5);
    return x ^ (x << 4);
  endfunction : xs
  task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] s);
    n_checks++;
    if (s !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk8
  // Waits n edges; a write strobe that wr left up is released first.
  task automatic wt(input int n);
    sfr_wr = 0;
    repeat (n) @(posedge clk);
    #5;
  endtask : wt
  // Byte write; the strobe stays up so writes in a row never drop and raise it in one step.
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    sfr_addr = a;
    sfr_wdata = v;
    sfr_wr = 1;
    @(posedge clk);
    #5;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    sfr_addr = a;
    sfr_rd = 1;
    wt(1);
    sfr_rd = 0;
    wt(1);
    chk8("rdata", e, sfr_rdata_r);
  endtask : rd
  task automatic final_report();
    $display("errors %0d checks %0d", num_errors, n_checks);
    if (num_errors == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : final_report
  // Reset, register defaults, random control traffic, then the counting modes.
  initial begin
    wt(4);
    rst_n = 1;
    rd(8'hC8, 8'h00);
    rd(8'hCA, 8'h00);
    rd(8'hCD, 8'h00);
    rd(8'hC9, 8'h00);
    for (b = 0; b < 8; b++) begin
      seed = xs(seed);
      d = seed & 8'h3F;
      wr(8'hC8, d);
      rd(8'hC8, d);
      bit_addr = 8'hC8 + 8'(b % 6);
      bit_val = seed[7];
      bit_wr = 1;
      wt(1);
      bit_wr = 0;
      d[b % 6] = seed[7];
      rd(8'hC8, d);
    end
    wr(8'hC8, 8'h00);
    high_byte_clock_sel = 1;
    low_byte_clock_sel = 1;
    wr(8'hCA, 8'h34);
    wr(8'hCB, 8'h12);
    wr(8'hCC, 8'hFE);
    wr(8'hCD, 8'hFF);
    wr(8'hC8, 8'h04);
    wt(4);
    rd(8'hC8, 8'hC4);
    chk8("irq", 8'h01, {7'h0, irq_req_r});
    rd(8'hCD, 8'h12);
    wr(8'hC8, 8'h00);
    wt(2);
    chk8("irq", 8'h00, {7'h0, irq_req_r});
    wr(8'hCD, 8'hFF);
    wr(8'hCC, 8'hF0);
    wr(8'hC8, 8'h08);
    wt(20);
    rd(8'hC8, 8'h48);
    rd(8'hCD, 8'hFF);
    chk8("irq", 8'h00, {7'h0, irq_req_r});
    wr(8'hC8, 8'h68);
    wt(2);
    chk8("irq", 8'h01, {7'h0, irq_req_r});
    timer_irq_enable = 0;
    wt(2);
    chk8("irq", 8'h00, {7'h0, irq_req_r});
    timer_irq_enable = 1;
    wr(8'hC8, 8'h16);
    comparator0_in = 1;
    wt(8);
    rd(8'hC8, 8'h96);
    rd(8'hCB, 8'hFF);
    // Split mode with the comparator as alternate clock of both bytes.
    wr(8'hC8, 8'h00);
    comparator0_in = 0;
    high_byte_clock_sel = 0;
    low_byte_clock_sel = 0;
    wr(8'hCA, 8'h55);
    wr(8'hCB, 8'h77);
    wr(8'hCC, 8'hFE);
    wr(8'hCD, 8'hFE);
    wr(8'hC8, 8'h0D);
    repeat (2) begin
      comparator0_in = 1;
      wt(5);
      comparator0_in = 0;
      wt(3);
    end
    rd(8'hC8, 8'hCD);
    rd(8'hCC, 8'h55);
    rd(8'hCD, 8'h77);
    chk8("irq", 8'h01, {7'h0, irq_req_r});
    // Capture on every eighth oscillator edge while the count stands still.
    wr(8'hC8, 8'h10);
    wr(8'hCA, 8'h00);
    wr(8'hCB, 8'h00);
    repeat (8) begin
      rtc_osc_in = 1;
      wt(3);
      rtc_osc_in = 0;
      wt(3);
    end
    rd(8'hC8, 8'h90);
    rd(8'hCB, 8'h77);
    rd(8'hCA, 8'h55);
    ce = 0;
    wt(3);
    ce = 1;
    final_report();
  end
endmodule : test_ttc_timer_two
`default_nettype wire
